// ===== capt_consts.svh
// Register map, field positions, reset values and sizes of the PWM timer
`ifndef CAPT_CONSTS_SVH
`define CAPT_CONSTS_SVH

`define CAPT_ADDR_W        8
`define CAPT_NUM_CHAN      2
`define CAPT_DIV_W         7

`define CAPT_IDX_CTRL      6'h00
`define CAPT_IDX_COUNT     6'h01
`define CAPT_IDX_MODULO    6'h02
`define CAPT_IDX_CHAN0     6'h04

`define CAPT_CTRL_PS_LSB   0
`define CAPT_CTRL_CS_LSB   3
`define CAPT_CTRL_CENTER   5
`define CAPT_COUNT_DOWN    16

`define CAPT_PS_RST        3'h0
`define CAPT_CS_RST        2'h0
`define CAPT_CS_STOP       2'h0
`define CAPT_MODULO_RST    16'hffff
`define CAPT_CHAN_RST      16'h0000
`define CAPT_COUNT_RST     16'h0000

`define CAPT_RESP_OKAY     2'h0
`define CAPT_RESP_SLVERR   2'h2

`endif

// ===== capt_pkg.sv
// Types shared by the PWM timer modules
package capt_pkg;

    typedef logic [15:0]                 capt_word_type;
    typedef logic [1:0]                  capt_chan_type;
    typedef logic [2:0]                  capt_ps_type;
    typedef logic [7:0]                  capt_addr_type;
    typedef logic [31:0]                 capt_data_type;
    typedef logic [3:0]                  capt_strb_type;
    typedef logic [1:0]                  capt_resp_type;

    typedef enum logic {CAPT_UP, CAPT_DOWN} capt_dir_type;

endpackage : capt_pkg

// ===== capt_prescaler.sv
// Free running divider that issues counter steps at the selected rate
`include "capt_consts.svh"
module capt_prescaler (
    // Clock and reset
    input  wire logic                CLK,
    input  wire logic                RESETN,
    // Control
    input  wire capt_pkg::capt_ps_type PS_SEL,
    input  wire logic                RUN,
    // Step output
    output logic                     TICK
);
    import capt_pkg::*;

    logic [`CAPT_DIV_W-1:0] div_ff;
    logic [`CAPT_DIV_W-1:0] div_mask;

    // Divider is never cleared by a new selection
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + `CAPT_DIV_W'h1;
        end
    end

    // Division by two to the power of the selection
    assign div_mask = `CAPT_DIV_W'((8'h1 << PS_SEL) - 8'h1);
    assign TICK     = RUN && ((div_ff & div_mask) == div_mask);

endmodule : capt_prescaler

// ===== capt_timer.sv
// Center and edge aligned PWM timer with AXI4-Lite register access
//
// Overview of operation
// - Center mode counts up to modulo, then down
// - Zero and modulo held once, others twice
// - Period starts stepping modulo-1 to modulo
// - Output from hidden flip-flop, reset low
// - Output changes only on a compare event
// - Channel equal modulo gives full duty
// - Negative channel value gives zero duty
// - Center mode modulo-1 gives duty value over modulo
// - Edge mode update may come period late
// - Prescaler divider not cleared on change
// - Prescale code one divides by two
// - Channel value written byte-wise, 16 bits
// - Center mode new value waits period start while running
// - Clock source zero stops the counter
// - Any counter write clears the counter
`include "capt_consts.svh"
module capt_timer (
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RESETN,
    // AXI4-Lite write
    input  wire capt_pkg::capt_addr_type AWADDR,
    input  wire logic                    AWVALID,
    output logic                         AWREADY,
    input  wire capt_pkg::capt_data_type WDATA,
    input  wire capt_pkg::capt_strb_type WSTRB,
    input  wire logic                    WVALID,
    output logic                         WREADY,
    output capt_pkg::capt_resp_type      BRESP,
    output logic                         BVALID,
    input  wire logic                    BREADY,
    // AXI4-Lite read
    input  wire capt_pkg::capt_addr_type ARADDR,
    input  wire logic                    ARVALID,
    output logic                         ARREADY,
    output capt_pkg::capt_data_type      RDATA,
    output capt_pkg::capt_resp_type      RRESP,
    output logic                         RVALID,
    input  wire logic                    RREADY,
    // PWM pins
    output capt_pkg::capt_chan_type      PWM_OUT
);
    import capt_pkg::*;

    localparam int NCH = `CAPT_NUM_CHAN;

    function automatic logic [5:0] reg_idx(input capt_addr_type a);
        reg_idx = a[7:2];
    endfunction : reg_idx

    function automatic logic mapped(input capt_addr_type a);
        logic [5:0] i;
        i = a[7:2];
        mapped = (i == `CAPT_IDX_CTRL) || (i == `CAPT_IDX_COUNT) || (i == `CAPT_IDX_MODULO)
               || ((i >= `CAPT_IDX_CHAN0) && (i < `CAPT_IDX_CHAN0 + 6'(NCH)));
    endfunction : mapped

    function automatic capt_word_type merge16(input capt_word_type old, input capt_data_type d,
                                              input capt_strb_type s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    ////////////////////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic          aw_got_ff;
    logic          w_got_ff;
    capt_addr_type aw_addr_ff;
    capt_data_type w_data_ff;
    capt_strb_type w_strb_ff;
    logic          bvalid_ff;
    capt_resp_type bresp_ff;
    logic          rvalid_ff;
    capt_resp_type rresp_ff;
    capt_data_type rdata_ff;
    logic          wr_do;
    logic [5:0]    wr_idx;

    assign AWREADY = !aw_got_ff && !bvalid_ff;
    assign WREADY  = !w_got_ff && !bvalid_ff;
    assign ARREADY = !rvalid_ff;
    assign BVALID  = bvalid_ff;
    assign BRESP   = bresp_ff;
    assign RVALID  = rvalid_ff;
    assign RRESP   = rresp_ff;
    assign RDATA   = rdata_ff;
    assign wr_do   = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_idx  = reg_idx(aw_addr_ff);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff  <= '0;
            w_strb_ff  <= '0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `CAPT_RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_got_ff  <= 1'b1;
                aw_addr_ff <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_got_ff  <= 1'b1;
                w_data_ff <= WDATA;
                w_strb_ff <= WSTRB;
            end
            if (wr_do) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= mapped(aw_addr_ff) ? `CAPT_RESP_OKAY : `CAPT_RESP_SLVERR;
            end else if (BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Control registers

    capt_ps_type   ps_ff;
    logic [1:0]    cs_ff;
    logic          center_ff;
    capt_word_type mod_ff;
    capt_word_type cv_ff [NCH];
    logic          run;
    logic          cnt_clr;

    assign run     = (cs_ff != `CAPT_CS_STOP);
    assign cnt_clr = wr_do && (wr_idx == `CAPT_IDX_COUNT);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ps_ff     <= `CAPT_PS_RST;
            cs_ff     <= `CAPT_CS_RST;
            center_ff <= 1'b0;
            mod_ff    <= `CAPT_MODULO_RST;
        end else if (wr_do) begin
            if (wr_idx == `CAPT_IDX_CTRL && w_strb_ff[0]) begin
                ps_ff     <= w_data_ff[`CAPT_CTRL_PS_LSB +: 3];
                cs_ff     <= w_data_ff[`CAPT_CTRL_CS_LSB +: 2];
                center_ff <= w_data_ff[`CAPT_CTRL_CENTER];
            end
            if (wr_idx == `CAPT_IDX_MODULO) begin
                mod_ff <= merge16(mod_ff, w_data_ff, w_strb_ff);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Prescaler and counter

    logic          tick;
    capt_word_type cnt_ff;
    capt_word_type nxt_cnt;
    capt_dir_type  dir_ff;
    capt_dir_type  nxt_dir;
    logic          step_dn;
    logic          period_start;
    logic          wrap;
    logic          load_cv;

    capt_prescaler u_prescaler (
        .CLK    (CLK),
        .RESETN (RESETN),
        .PS_SEL (ps_ff),
        .RUN    (run),
        .TICK   (tick)
    );

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_dir = dir_ff;
        step_dn = 1'b0;
        if (cnt_clr) begin
            nxt_cnt = `CAPT_COUNT_RST;
        end else if (tick) begin
            if (!center_ff) begin
                nxt_dir = CAPT_UP;
                nxt_cnt = (cnt_ff >= mod_ff) ? 16'h0000 : cnt_ff + 16'h0001;
            end else if (dir_ff == CAPT_DOWN) begin
                if (cnt_ff == 16'h0000) begin
                    nxt_dir = CAPT_UP;
                    nxt_cnt = (mod_ff == 16'h0000) ? 16'h0000 : 16'h0001;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                    step_dn = 1'b1;
                end
            end else if (cnt_ff >= mod_ff) begin
                nxt_dir = CAPT_DOWN;
                nxt_cnt = (cnt_ff == 16'h0000) ? 16'h0000 : cnt_ff - 16'h0001;
                step_dn = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
        end
    end

    assign period_start = tick && !cnt_clr && center_ff && dir_ff == CAPT_UP
                          && cnt_ff == mod_ff - 16'h0001;
    assign wrap         = tick && !cnt_clr && !center_ff && cnt_ff >= mod_ff;
    assign load_cv      = period_start || wrap || !run;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cnt_ff <= `CAPT_COUNT_RST;
            dir_ff <= CAPT_UP;
        end else begin
            cnt_ff <= nxt_cnt;
            dir_ff <= nxt_dir;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Channels

    capt_word_type act_ff [NCH];
    logic [NCH-1:0] out_ff;
    logic [NCH-1:0] evt;

    generate
        for (genvar c = 0; c < NCH; c++) begin : g_chan
            capt_word_type eff;
            logic          hit;
            assign eff = load_cv ? cv_ff[c] : act_ff[c];
            assign hit = tick && !cnt_clr && !eff[15] && nxt_cnt == eff;
            assign evt[c] = wrap || hit || (period_start && eff[15]);

            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    cv_ff[c] <= `CAPT_CHAN_RST;
                end else if (wr_do && wr_idx == `CAPT_IDX_CHAN0 + 6'(c)) begin
                    cv_ff[c] <= merge16(cv_ff[c], w_data_ff, w_strb_ff);
                end
            end

            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    act_ff[c] <= `CAPT_CHAN_RST;
                end else if (load_cv) begin
                    act_ff[c] <= cv_ff[c];
                end
            end

            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    out_ff[c] <= 1'b0;
                end else if (wrap) begin
                    out_ff[c] <= (eff != 16'h0000) && !eff[15];
                end else if (period_start && eff[15]) begin
                    out_ff[c] <= 1'b0;
                end else if (hit) begin
                    if (nxt_cnt == mod_ff) begin
                        out_ff[c] <= 1'b1;
                    end else if (nxt_cnt == 16'h0000) begin
                        out_ff[c] <= 1'b0;
                    end else begin
                        out_ff[c] <= center_ff && step_dn;
                    end
                end
            end
        end
    endgenerate

    assign PWM_OUT = out_ff;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [5:0]    rd_idx;
    capt_data_type rd_val;

    assign rd_idx = reg_idx(ARADDR);

    always_comb begin
        rd_val = '0;
        if (rd_idx == `CAPT_IDX_CTRL) begin
            rd_val[`CAPT_CTRL_PS_LSB +: 3] = ps_ff;
            rd_val[`CAPT_CTRL_CS_LSB +: 2] = cs_ff;
            rd_val[`CAPT_CTRL_CENTER]      = center_ff;
        end else if (rd_idx == `CAPT_IDX_COUNT) begin
            rd_val[15:0]             = cnt_ff;
            rd_val[`CAPT_COUNT_DOWN] = (dir_ff == CAPT_DOWN);
        end else if (rd_idx == `CAPT_IDX_MODULO) begin
            rd_val[15:0] = mod_ff;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (rd_idx == `CAPT_IDX_CHAN0 + 6'(c)) begin
                    rd_val[15:0] = cv_ff[c];
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= `CAPT_RESP_OKAY;
            rdata_ff  <= '0;
        end else if (ARVALID && ARREADY) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= mapped(ARADDR) ? `CAPT_RESP_OKAY : `CAPT_RESP_SLVERR;
            rdata_ff  <= rd_val;
        end else if (RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_top_reached;
        period_start && !wr_do;
    endsequence

    sequence s_quiet_step;
        tick && center_ff && !wr_do && !cnt_clr;
    endsequence

    cnt_stop_hold_a: assert property (!run && !cnt_clr |=> $stable(cnt_ff))
        else $error("Counter moved with clock source off");
    cnt_write_clr_a: assert property (cnt_clr |=> cnt_ff == 16'h0000)
        else $error("Counter write did not clear count");
    center_up_step_a: assert property (s_quiet_step ##0 dir_ff == CAPT_UP && cnt_ff < mod_ff
                                       |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("Center up count did not increment");
    center_turn_a: assert property (s_quiet_step ##0 cnt_ff == mod_ff && mod_ff > 16'h0001
                                    |=> dir_ff == CAPT_DOWN && cnt_ff == mod_ff - 16'h0001)
        else $error("Counter did not turn down after modulo");
    period_start_a: assert property (s_top_reached |=> cnt_ff == mod_ff)
        else $error("Period start did not reach modulo");
    full_duty_a: assert property (s_top_reached ##0 cv_ff[0] == mod_ff |=> PWM_OUT[0])
        else $error("Channel at modulo not active");
    zero_duty_a: assert property (s_top_reached ##0 cv_ff[0][15] |=> !PWM_OUT[0])
        else $error("Negative channel value not inactive");
    out_hold_a: assert property (!evt[0] |=> $stable(PWM_OUT[0]))
        else $error("Output changed without compare event");
    cv_buffer_a: assert property (center_ff && run && !period_start
                                  |=> $stable(act_ff[0]))
        else $error("Channel value applied mid period");
    div_two_a: assert property (ps_ff == 3'h1 && tick ##1 ps_ff == 3'h1 |-> !tick)
        else $error("Divide by two ticked twice in a row");

endmodule : capt_timer

// ===== capt_load_model.sv
// Load model that integrates the PWM pins and times channel zero
module capt_load_model (
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RESETN,
    // Observed pins and measurement clear
    input  wire capt_pkg::capt_chan_type PWM_IN,
    input  wire logic                   CLR,
    // Measurements
    output logic [31:0]                 HIGH0,
    output logic [31:0]                 HIGH1,
    output logic [31:0]                 PERIOD0
);
    timeunit 1ns;
    timeprecision 1ps;
    import capt_pkg::*;

    logic [31:0] high0_ff;
    logic [31:0] high1_ff;
    logic [31:0] period0_ff;
    logic [31:0] since_ff;
    logic        last_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Active cycle totals since the last clear
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            high0_ff <= '0;
            high1_ff <= '0;
        end else if (CLR) begin
            high0_ff <= '0;
            high1_ff <= '0;
        end else begin
            high0_ff <= high0_ff + 32'(PWM_IN[0]);
            high1_ff <= high1_ff + 32'(PWM_IN[1]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Cycles between rising edges of channel zero
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            since_ff   <= '0;
            period0_ff <= '0;
            last_ff    <= 1'b0;
        end else begin
            last_ff <= PWM_IN[0];
            if (PWM_IN[0] && !last_ff) begin
                period0_ff <= since_ff + 32'h1;
                since_ff   <= '0;
            end else begin
                since_ff <= since_ff + 32'h1;
            end
        end
    end

    assign HIGH0   = high0_ff;
    assign HIGH1   = high1_ff;
    assign PERIOD0 = period0_ff;
endmodule : capt_load_model

// ===== center_aligned_pwm_timer_tb.sv
// Self-checking bench for the PWM timer
`include "capt_consts.svh"
module center_aligned_pwm_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import capt_pkg::*;

    localparam capt_addr_type A_CTRL = {`CAPT_IDX_CTRL, 2'b00};
    localparam capt_addr_type A_CNT  = {`CAPT_IDX_COUNT, 2'b00};
    localparam capt_addr_type A_MOD  = {`CAPT_IDX_MODULO, 2'b00};
    localparam capt_addr_type A_CH0  = {`CAPT_IDX_CHAN0, 2'b00};
    localparam capt_addr_type A_CH1  = A_CH0 + 8'h04;

    logic          clk, resetn, clr;
    logic          awvalid, awready, wvalid, wready, bvalid, bready;
    logic          arvalid, arready, rvalid, rready;
    capt_addr_type awaddr, araddr;
    capt_data_type wdata, rdata, rd;
    capt_strb_type wstrb;
    capt_resp_type bresp, rresp, rs;
    capt_chan_type pwm;
    logic [31:0]   high0, high1, per0;
    int            num_errors, tests_run;
    capt_word_type vals [5] = '{16'h0007, 16'h0008, 16'h8000, 16'hffff, 16'h0000};
    logic [31:0]   expv [5] = '{32'h1c, 32'h20, 32'h0, 32'h0, 32'h0};

    capt_timer dut_u (.CLK(clk), .RESETN(resetn), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(rready), .PWM_OUT(pwm));

    capt_load_model load_u (.CLK(clk), .RESETN(resetn), .PWM_IN(pwm), .CLR(clr),
        .HIGH0(high0), .HIGH1(high1), .PERIOD0(per0));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and bus tasks
    task automatic report_and_stop;
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic give_up;
        num_errors++;
        report_and_stop();
    endtask : give_up

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input capt_addr_type a, input capt_data_type d, input capt_strb_type s,
                      output capt_resp_type r);
        int   n;
        logic ad, wd, ah, wh;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge clk);
            ah = awvalid && awready && !ad;
            wh = wvalid && wready && !wd;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            ad = ad | ah;
            wd = wd | wh;
            n++;
            if (n > 50) give_up();
        end while (!(ad && wd));
        do begin
            @(negedge clk);
            n++;
            if (n > 100) give_up();
        end while (bvalid !== 1'b1);
        r = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask : wr

    task automatic rd_reg(input capt_addr_type a, output capt_data_type d,
                          output capt_resp_type r);
        int n;
        n = 0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge clk);
            n++;
            if (n > 50) give_up();
        end while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do begin
            @(negedge clk);
            n++;
            if (n > 100) give_up();
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask : rd_reg

    task automatic rchk(input capt_addr_type a, input logic [31:0] exp, input string name);
        rd_reg(a, rd, rs);
        check(name, rd, exp);
        check("read resp", 32'(rs), 32'(`CAPT_RESP_OKAY));
    endtask : rchk

    task automatic measure(input int w);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (w) @(posedge clk);
        @(negedge clk);
    endtask : measure

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {resetn, clr, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        num_errors = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check("pwm after reset", 32'(pwm), 32'h0);
        rchk(A_CTRL, 32'h0, "ctrl reset");
        rchk(A_CNT, 32'h0, "count reset");
        rchk(A_MOD, 32'h0000ffff, "modulo reset");
        rchk(A_CH1, 32'h0, "chan1 reset");
        rd_reg(8'h0c, rd, rs);
        check("unmapped read", {rd[29:0], rs}, {30'h0, `CAPT_RESP_SLVERR});
        wr(8'h0c, 32'h5, 4'hf, rs);
        check("unmapped write", 32'(rs), 32'(`CAPT_RESP_SLVERR));
        wr(A_CH0, 32'h000000ab, 4'h1, rs);
        wr(A_CH0, 32'h00001200, 4'h2, rs);
        rchk(A_CH0, 32'h000012ab, "byte lanes");
        repeat (20) @(posedge clk);
        rchk(A_CNT, 32'h0, "stopped count");
        wr(A_MOD, 32'h8, 4'h3, rs);
        wr(A_CH0, 32'h4, 4'h3, rs);
        wr(A_CH1, 32'h8, 4'h3, rs);
        wr(A_CTRL, 32'h28, 4'h1, rs);
        repeat (64) @(posedge clk);
        measure(32);
        check("half duty", high0, 32'h10);
        check("full duty", high1, 32'h20);
        check("center period", per0, 32'h10);
        rd_reg(A_CNT, rd, rs);
        check("count bound", 32'(rd[15:0] <= 16'h8), 32'h1);
        foreach (vals[i]) begin
            wr(A_CH0, {16'h0, vals[i]}, 4'h3, rs);
            repeat (48) @(posedge clk);
            measure(32);
            check("duty table", high0, expv[i]);
        end
        wr(A_CH0, 32'h4, 4'h3, rs);
        wr(A_CTRL, 32'h39, 4'h1, rs);
        repeat (128) @(posedge clk);
        measure(64);
        check("divided duty", high0, 32'h20);
        check("divided period", per0, 32'h20);
        check("full before stop", 32'(pwm[1]), 32'h1);
        wr(A_CTRL, 32'h20, 4'h1, rs);
        wr(A_CNT, 32'h1234, 4'hf, rs);
        rd_reg(A_CNT, rd, rs);
        check("count cleared", 32'(rd[15:0]), 32'h0);
        repeat (20) @(posedge clk);
        @(negedge clk);
        check("held level", 32'(pwm[1]), 32'h1);
        rd_reg(A_CNT, rd, rs);
        check("count held", 32'(rd[15:0]), 32'h0);
        wr(A_CH0, 32'h3, 4'h3, rs);
        wr(A_CTRL, 32'h10, 4'h1, rs);
        repeat (60) @(posedge clk);
        measure(36);
        check("edge duty", high0, 32'hc);
        check("edge period", per0, 32'h9);
        report_and_stop();
    end
endmodule : center_aligned_pwm_timer_tb
